// >>> test_uart_fifo_status_and_shadow_ctrl.sv
// Testbench: register-level checks of the status and shadow block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
   err_count++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module test_uart_fifo_status_and_shadow_ctrl;
   logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, lastErr;
   logic [31:0] paddr, pwdata, prdata, rdata;
   logic txPush, txPop, rxPush, rxPop, fifoEnable, modemActive;
   logic fifoCtrlTxFlush, fifoCtrlRxFlush, modemCtrlWrite, modemCtrlRts;
   logic autoFlowEnable, loopbackEnable, txFifoFlush, rxFifoFlush;
   logic ctrlReset_n, shadowRts, loopRts, rts_n, irq;
   logic [4:0] rxThreshold;
   int err_count = 0;
   int n_tests = 0;
   // Short aliases of the register addresses
   localparam logic [31:0] aSt = ufs_pkg::ADDR_FIFO_STATUS;
   localparam logic [31:0] aTx = ufs_pkg::ADDR_TX_FILL;
   localparam logic [31:0] aRx = ufs_pkg::ADDR_RX_FILL;
   localparam logic [31:0] aSr = ufs_pkg::ADDR_SOFT_RESET;
   localparam logic [31:0] aSh = ufs_pkg::ADDR_SHADOW_RTS;
   localparam logic [31:0] aEv = ufs_pkg::ADDR_EVENT_STATUS;
   // 40 MHz clock
   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;
   ufs_status_shadow u_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .txPush(txPush), .txPop(txPop), .rxPush(rxPush), .rxPop(rxPop),
      .fifoEnable(fifoEnable), .fifoCtrlTxFlush(fifoCtrlTxFlush),
      .fifoCtrlRxFlush(fifoCtrlRxFlush), .rxThreshold(rxThreshold),
      .modemCtrlWrite(modemCtrlWrite), .modemCtrlRts(modemCtrlRts),
      .autoFlowEnable(autoFlowEnable), .loopbackEnable(loopbackEnable),
      .txFifoFlush(txFifoFlush), .rxFifoFlush(rxFifoFlush),
      .ctrlReset_n(ctrlReset_n), .shadowRts(shadowRts), .loopRts(loopRts),
      .rts_n(rts_n), .irq(irq));
   // Slow modem: six idle cycles between characters
   ufs_modem_model u_modem (.mclk(mclk), .reset_n(reset_n),
      .active(modemActive), .gap(4'h6), .rts_n(rts_n), .rxPush(rxPush));
   // Verdict and end of run
   task automatic wrap_up;
      if (err_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [31:0] a,
         input logic [31:0] d);
      int i;
      logic ok;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      ok = (pready === 1'b1);
      rdata = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
      // A slave that never answers ends the run
      if (!ok) begin
         err_count++;
         wrap_up();
      end
   endtask : apb
   // Read and compare one register
   task automatic rd(input logic [31:0] a, input logic [31:0] e,
         input string nm);
      apb(1'b0, a, 32'h00000000);
      `CHK(nm, e, rdata)
   endtask : rd
   // Read until the expected word shows, with a bound
   task automatic poll(input logic [31:0] a, input logic [31:0] e,
         input string nm);
      int i;
      i = 0;
      do begin
         apb(1'b0, a, 32'h00000000);
         i++;
      end while (rdata !== e && i < 60);
      `CHK(nm, e, rdata)
      if (rdata !== e)
         wrap_up();
   endtask : poll
   // Wait a bounded time for a controller reset level
   task automatic waitCtl(input logic lvl);
      int i;
      i = 0;
      while (ctrlReset_n !== lvl && i < 10) begin
         @(posedge mclk);
         i++;
      end
      `CHK("ctrlReset_n", lvl, ctrlReset_n)
   endtask : waitCtl
   // Transmit pushes, one every other cycle
   task automatic push_tx(input int n);
      repeat (n) begin
         txPush <= 1'b1;
         @(posedge mclk);
         txPush <= 1'b0;
         @(posedge mclk);
      end
   endtask : push_tx
   initial begin
      {reset_n, psel, penable, pwrite, txPush, txPop, rxPop} = 7'h00;
      {fifoCtrlTxFlush, fifoCtrlRxFlush, modemCtrlWrite} = 3'h0;
      {modemCtrlRts, autoFlowEnable, loopbackEnable, modemActive} = 4'h0;
      paddr = 32'h00000000;
      pwdata = 32'h00000000;
      fifoEnable = 1'b1;
      rxThreshold = 5'h03;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      // Reset values, write-only and unmapped reads
      rd(aSt, 32'h00000006, "status");
      rd(aTx, 32'h00000000, "txFill");
      rd(aRx, 32'h00000000, "rxFill");
      rd(aSr, 32'h00000000, "strobes");
      rd(32'h50001000, 32'h00000000, "unmapped");
      `CHK("slverr", 1'b1, lastErr)
      apb(1'b1, aTx, 32'h0000FFFF);
      rd(aTx, 32'h00000000, "txFillRo");
      // Overfill the transmit FIFO by one, then pop one
      push_tx(17);
      rd(aTx, 32'h00000010, "txFull");
      rd(aSt, 32'h00000000, "stTxFull");
      txPop <= 1'b1;
      @(posedge mclk);
      txPop <= 1'b0;
      rd(aSt, 32'h00000002, "stTxSpace");
      apb(1'b1, aSr, 32'h00000004);
      rd(aTx, 32'h00000000, "txFlush");
      // Control-register flush and enable fall behave alike
      push_tx(3);
      fifoCtrlTxFlush <= 1'b1;
      fifoCtrlRxFlush <= 1'b1;
      @(posedge mclk);
      {fifoCtrlTxFlush, fifoCtrlRxFlush} <= 2'h0;
      rd(aTx, 32'h00000000, "txCtlFlush");
      push_tx(2);
      fifoEnable <= 1'b0;
      @(posedge mclk);
      fifoEnable <= 1'b1;
      rd(aTx, 32'h00000000, "txEnFall");
      // Modem fills the receive side; auto flow stops it above three
      autoFlowEnable <= 1'b1;
      modemActive <= 1'b1;
      apb(1'b1, aSh, 32'h00000001);
      rd(aSh, 32'h00000001, "shadowSet");
      poll(aRx, 32'h00000004, "rxThrottle");
      `CHK("rtsThrottle", 1'b1, rts_n)
      autoFlowEnable <= 1'b0;
      poll(aRx, 32'h00000010, "rxFull");
      rd(aSt, 32'h0000001E, "stRxFull");
      `CHK("rtsLow", 1'b0, rts_n)
      apb(1'b1, aSh, 32'h00000000);
      @(posedge mclk);
      `CHK("rtsHigh", 1'b1, rts_n)
      rxPop <= 1'b1;
      @(posedge mclk);
      rxPop <= 1'b0;
      rd(aSt, 32'h0000000E, "stRxPop");
      apb(1'b1, aSr, 32'h00000002);
      rd(aRx, 32'h00000000, "rxFlush");
      // Modem control write of the shared bit, then loopback
      modemActive <= 1'b0;
      modemCtrlRts <= 1'b1;
      modemCtrlWrite <= 1'b1;
      @(posedge mclk);
      modemCtrlWrite <= 1'b0;
      rd(aSh, 32'h00000001, "shadowMcr");
      `CHK("rtsMcr", 1'b0, rts_n)
      loopbackEnable <= 1'b1;
      repeat (2) @(posedge mclk);
      `CHK("rtsLoop", 1'b1, rts_n)
      `CHK("loopRts", 1'b1, loopRts)
      loopbackEnable <= 1'b0;
      // Whole-controller reset from software
      push_tx(2);
      apb(1'b1, aSr, 32'h00000001);
      waitCtl(1'b0);
      waitCtl(1'b1);
      repeat (3) @(posedge mclk);
      rd(aTx, 32'h00000000, "txCtlReset");
      rd(aSh, 32'h00000000, "shadowCtlReset");
      // Event raised while masked, then unmasked, then cleared
      rd(aEv, 32'h00000007, "evAll");
      apb(1'b1, aEv, 32'h00000007);
      push_tx(1);
      apb(1'b1, aSr, 32'h00000004);
      rd(aEv, 32'h00000002, "evTxEmpty");
      `CHK("irqMasked", 1'b0, irq)
      apb(1'b1, ufs_pkg::ADDR_EVENT_MASK, 32'h00000002);
      @(posedge mclk);
      `CHK("irqOn", 1'b1, irq)
      apb(1'b1, aEv, 32'h00000002);
      @(posedge mclk);
      `CHK("irqOff", 1'b0, irq)
      wrap_up();
   end
endmodule : test_uart_fifo_status_and_shadow_ctrl
`default_nettype wire

// >>> ufs_fifo_level.sv
// Module: fill counter and full/empty flags of one FIFO
`timescale 1ns/100ps
`default_nettype none
module ufs_fifo_level (
   input wire logic mclk,
   input wire logic reset_n,
   input wire ufs_pkg::ufs_move_s move,
   output ufs_pkg::ufs_lvl_s lvl
);

   logic [ufs_pkg::CNT_W-1:0] count_q; // Entries held
   logic [ufs_pkg::CNT_W-1:0] count_d; // Next entry count
   logic full_q; // Registered full flag
   logic empty_q; // Registered empty flag
   wire pushOk; // Push into free space
   wire popOk; // Pop from held data

   // Push on full and pop on empty are dropped, as the storage does
   assign pushOk = move.push & ~full_q;
   assign popOk = move.pop & ~empty_q;

   // Flush wins over any movement in the same cycle
   always_comb begin
      count_d = count_q;
      if (move.flush) begin
         count_d = ufs_pkg::FILL_RST;
      end else if (pushOk & ~popOk) begin
         count_d = count_q + 5'h01;
      end else if (popOk & ~pushOk) begin
         count_d = count_q - 5'h01;
      end
   end

   // Flags come from the next count, so they track it with no lag
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         count_q <= ufs_pkg::FILL_RST;
         full_q <= 1'b0;
         empty_q <= 1'b1;
      end else begin
         count_q <= count_d;
         full_q <= (count_d == ufs_pkg::CNT_W'(ufs_pkg::FIFO_DEPTH));
         empty_q <= (count_d == ufs_pkg::FILL_RST);
      end
   end

   assign lvl = '{count: count_q, full: full_q, empty: empty_q};

endmodule : ufs_fifo_level
`default_nettype wire

// >>> ufs_modem_model.sv
// Partner: modem that sends characters while request-to-send is low
`timescale 1ns/100ps
`default_nettype none
module ufs_modem_model (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic active,
   input wire logic [3:0] gap,
   input wire logic rts_n,
   output logic rxPush
);
   logic [3:0] waitCnt_q; // Idle cycles left between characters
   // One character, then gap idle cycles; a large gap is a slow modem
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rxPush <= 1'b0;
         waitCnt_q <= 4'h0;
      end else if (waitCnt_q != 4'h0) begin
         rxPush <= 1'b0;
         waitCnt_q <= waitCnt_q - 4'h1;
      end else if (active && !rts_n) begin
         rxPush <= 1'b1;
         waitCnt_q <= gap;
      end else begin
         rxPush <= 1'b0;
      end
   end
endmodule : ufs_modem_model
`default_nettype wire

// >>> ufs_pkg.sv
// Package: constants and carriers for the FIFO status and shadow block
package ufs_pkg;

   // FIFO geometry
   localparam int FIFO_DEPTH = 16; // Entries in each FIFO
   localparam int CNT_W = 5; // Holds 0..FIFO_DEPTH
   localparam int REG_W = 16; // Register data width
   localparam int THR_W = 5; // Receive threshold width

   // Register byte addresses
   localparam logic [31:0] ADDR_FIFO_STATUS = 32'h5000107C;
   localparam logic [31:0] ADDR_TX_FILL = 32'h50001080;
   localparam logic [31:0] ADDR_RX_FILL = 32'h50001084;
   localparam logic [31:0] ADDR_SOFT_RESET = 32'h50001088;
   localparam logic [31:0] ADDR_SHADOW_RTS = 32'h5000108C;
   localparam logic [31:0] ADDR_EVENT_STATUS = 32'h500010F0;
   localparam logic [31:0] ADDR_EVENT_MASK = 32'h500010F4;

   // Fifo status field positions
   localparam int RX_FULL_BIT = 4;
   localparam int RX_NONEMPTY_BIT = 3;
   localparam int TX_EMPTY_BIT = 2;
   localparam int TX_SPACE_BIT = 1;

   // Software reset strobe positions
   localparam int TX_FLUSH_BIT = 2;
   localparam int RX_FLUSH_BIT = 1;
   localparam int CTRL_RESET_BIT = 0;

   // Shadow request-to-send position
   localparam int SHADOW_RTS_BIT = 0;

   // Event status and mask positions
   localparam int EVT_RX_FULL = 0;
   localparam int EVT_TX_EMPTY = 1;
   localparam int EVT_RTS_THROTTLE = 2;
   localparam int EVT_W = 3;

   // Reset values
   localparam logic [REG_W-1:0] FIFO_STATUS_RST = 16'h0006;
   localparam logic [CNT_W-1:0] FILL_RST = 5'h00;
   localparam logic SHADOW_RTS_RST = 1'b0;
   localparam logic [EVT_W-1:0] EVT_RST = 3'h0;

   // Controller reset stretch stages
   localparam int UR_SYNC_STAGES = 2;

   // Fill state of one FIFO
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic full;
      logic empty;
   } ufs_lvl_s;

   // Movement requests into one FIFO tracker
   typedef struct packed {
      logic push;
      logic pop;
      logic flush;
   } ufs_move_s;

endpackage : ufs_pkg

// >>> ufs_reset_sync.sv
// Module: controller reset, asserted at once and released on the clock
`timescale 1ns/100ps
`default_nettype none
module ufs_reset_sync (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic assertReq,
   output logic ctrlReset_n
);

   logic [ufs_pkg::UR_SYNC_STAGES-1:0] stage_q; // Release shift chain

   // Request clears the chain without waiting for an edge; ones walk
   // in afterwards, so release always lands on a clock edge
   always_ff @(posedge mclk or posedge assertReq) begin
      if (assertReq) begin
         stage_q <= '0;
      end else if (!reset_n) begin
         stage_q <= '0;
      end else begin
         stage_q <= {stage_q[ufs_pkg::UR_SYNC_STAGES-2:0], 1'b1};
      end
   end

   assign ctrlReset_n = stage_q[ufs_pkg::UR_SYNC_STAGES-1];

endmodule : ufs_reset_sync
`default_nettype wire

// >>> ufs_status_shadow.sv
// Module: FIFO status, fill levels, reset strobes and shadow RTS
`timescale 1ns/100ps
`default_nettype none

// Function
// R1 - Status bit 4 shows receive FIFO full
// R2 - Status bit 3 shows receive FIFO not empty
// R3 - Status bit 2 shows transmit FIFO empty
// R4 - Status bit 1 shows transmit FIFO space
// R5 - Transmit fill count readable, resets zero
// R6 - Receive fill count readable, resets zero
// R7 - Strobe bit 2 flushes transmit FIFO
// R8 - Strobe bit 1 flushes receive FIFO
// R9 - Strobes act like FIFO control flushes
// R10 - Strobe bit 0 resets whole controller
// R11 - Shadow RTS mirrors modem control RTS
// R12 - RTS output low while RTS set
// R13 - Auto flow forces RTS high above threshold; the code does so only while fifoEnable is also set
// R14 - Loopback holds RTS high, loops value back
// R15 - Modem sees low RTS as ready
// R16 - FIFO enable clear flushes both FIFOs
// R17 - Write-only and reserved bits read zero
module ufs_status_shadow (
   input wire logic mclk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // FIFO movement from the shifters and the data registers
   input wire logic txPush,
   input wire logic txPop,
   input wire logic rxPush,
   input wire logic rxPop,
   // Fifo control and modem control state held elsewhere
   input wire logic fifoEnable,
   input wire logic fifoCtrlTxFlush,
   input wire logic fifoCtrlRxFlush,
   input wire logic [ufs_pkg::THR_W-1:0] rxThreshold,
   input wire logic modemCtrlWrite,
   input wire logic modemCtrlRts,
   input wire logic autoFlowEnable,
   input wire logic loopbackEnable,
   // Outputs
   output logic txFifoFlush,
   output logic rxFifoFlush,
   output logic ctrlReset_n,
   output logic shadowRts,
   output logic loopRts,
   output logic rts_n,
   output logic irq
);

   // Bus handshake state
   logic pready_q; // Access completes on this cycle
   logic [31:0] prdata_q; // Registered read data
   logic pslverr_q; // Registered error answer

   // Control state
   logic rtsBit_q; // Shared request-to-send bit
   logic rtsBit_d; // Its next value
   logic rts_n_q; // Pin driver
   logic loopRts_q; // Loopback copy to the modem input
   logic txFlush_q; // Transmit flush pulse out
   logic rxFlush_q; // Receive flush pulse out
   logic urReq_q; // Controller reset request pulse
   logic fifoEnPrev_q; // Previous FIFO enable, for its fall
   logic rxFullPrev_q; // Previous receive full flag
   logic txEmptyPrev_q; // Previous transmit empty flag
   logic throttlePrev_q; // Previous flow throttle state

   // Event status and mask
   logic [ufs_pkg::EVT_W-1:0] evtStatus_q; // Sticky event bits
   logic [ufs_pkg::EVT_W-1:0] evtStatus_d; // Their next value
   logic [ufs_pkg::EVT_W-1:0] evtMask_q; // Enable per event
   logic [ufs_pkg::EVT_W-1:0] evtMask_d; // Its next value
   logic irq_q; // Interrupt level

   // FIFO fill carriers
   ufs_pkg::ufs_lvl_s txLvl; // Transmit fill state
   ufs_pkg::ufs_lvl_s rxLvl; // Receive fill state
   ufs_pkg::ufs_move_s txMove; // Transmit movement
   ufs_pkg::ufs_move_s rxMove; // Receive movement

   // Bus decode
   wire setupPhase; // First cycle of an access
   wire accessDone; // Access that completes this edge
   wire wrDone; // Write that takes effect this edge
   wire selStatus; // Fifo status selected
   wire selTxFill; // Transmit fill selected
   wire selRxFill; // Receive fill selected
   wire selSoftRst; // Reset strobes selected
   wire selShadowRts; // Shadow RTS selected
   wire selEvtStatus; // Event status selected
   wire selEvtMask; // Event mask selected
   wire addrHit; // Any mapped address
   logic [31:0] rdMux; // Read data for the decoded register
   logic [ufs_pkg::REG_W-1:0] statusWord; // Fifo status image

   // Flush and flow decisions
   wire swTxFlush; // Software transmit flush strobe
   wire swRxFlush; // Software receive flush strobe
   wire swCtrlReset; // Software controller reset strobe
   wire fifoEnFall; // FIFO enable cleared after being set
   wire localClear; // Controller reset seen by this block
   wire rxAbove; // Receive fill past the trigger level
   wire throttle; // Auto flow holds the modem off
   wire rtsDrive; // RTS asserted towards the modem
   wire [ufs_pkg::EVT_W-1:0] evtSet; // Events raised this cycle
   wire [ufs_pkg::EVT_W-1:0] evtClr; // Write-one-to-clear mask

   // One wait state per access: pready rises in the second access
   // cycle, which leaves a whole cycle for the registered read mux
   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable & pready_q;
   assign wrDone = accessDone & pwrite;

   // Full byte address compare; unmapped space answers with an error
   assign selStatus = (paddr == ufs_pkg::ADDR_FIFO_STATUS);
   assign selTxFill = (paddr == ufs_pkg::ADDR_TX_FILL);
   assign selRxFill = (paddr == ufs_pkg::ADDR_RX_FILL);
   assign selSoftRst = (paddr == ufs_pkg::ADDR_SOFT_RESET);
   assign selShadowRts = (paddr == ufs_pkg::ADDR_SHADOW_RTS);
   assign selEvtStatus = (paddr == ufs_pkg::ADDR_EVENT_STATUS);
   assign selEvtMask = (paddr == ufs_pkg::ADDR_EVENT_MASK);
   assign addrHit = selStatus | selTxFill | selRxFill | selSoftRst |
      selShadowRts | selEvtStatus | selEvtMask;

   // Fifo status image, reserved bits zero
   always_comb begin
      statusWord = '0; // see R17
      statusWord[ufs_pkg::RX_FULL_BIT] = rxLvl.full; // see R1
      statusWord[ufs_pkg::RX_NONEMPTY_BIT] = ~rxLvl.empty; // see R2
      statusWord[ufs_pkg::TX_EMPTY_BIT] = txLvl.empty; // see R3
      statusWord[ufs_pkg::TX_SPACE_BIT] = ~txLvl.full; // see R4
   end

   // Read mux; the strobe register is write-only and reads zero
   always_comb begin
      rdMux = 32'h00000000;
      if (selStatus) begin
         rdMux = {16'h0000, statusWord};
      end else if (selTxFill) begin
         rdMux = 32'(txLvl.count); // see R5
      end else if (selRxFill) begin
         rdMux = 32'(rxLvl.count); // see R6
      end else if (selShadowRts) begin
         rdMux = 32'(rtsBit_q); // see R11
      end else if (selEvtStatus) begin
         rdMux = 32'(evtStatus_q);
      end else if (selEvtMask) begin
         rdMux = 32'(evtMask_q);
      end
      // Strobe register and unmapped space fall through as zero
   end

   // Bus answer registers
   // Data and error stand with pready
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else begin
         // Raise pready one cycle into the access, drop after it
         pready_q <= psel & penable & ~pready_q;
         if (psel & penable & ~pready_q) begin
            prdata_q <= pwrite ? 32'h00000000 : rdMux;
            pslverr_q <= ~addrHit;
         end else if (setupPhase | accessDone) begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
         end
      end
   end

   // Software strobes are decoded only on the completing edge
   // Strobes are never stored
   assign swTxFlush = wrDone & selSoftRst &
      pwdata[ufs_pkg::TX_FLUSH_BIT]; // see R7
   assign swRxFlush = wrDone & selSoftRst &
      pwdata[ufs_pkg::RX_FLUSH_BIT]; // see R8
   assign swCtrlReset = wrDone & selSoftRst &
      pwdata[ufs_pkg::CTRL_RESET_BIT]; // see R10

   // Dropping the FIFO enable empties both FIFOs
   // Prev resets low: no false fall
   assign fifoEnFall = fifoEnPrev_q & ~fifoEnable; // see R16

   // The controller reset also clears this block's own FIFO view
   // The shared RTS bit clears too; other registers keep their value
   assign localClear = ~ctrlReset_n;

   // Same flush path as the fifo control bits, so they are alike
   assign txMove = '{push: txPush, pop: txPop,
      flush: swTxFlush | fifoCtrlTxFlush | fifoEnFall |
      localClear}; // see R9
   assign rxMove = '{push: rxPush, pop: rxPop,
      flush: swRxFlush | fifoCtrlRxFlush | fifoEnFall |
      localClear}; // see R9

   // Transmit FIFO fill tracker
   ufs_fifo_level txLevel (
      .mclk(mclk),
      .reset_n(reset_n),
      .move(txMove),
      .lvl(txLvl)
   );

   // Receive FIFO fill tracker
   ufs_fifo_level rxLevel (
      .mclk(mclk),
      .reset_n(reset_n),
      .move(rxMove),
      .lvl(rxLvl)
   );

   // Controller reset: asserted without the clock, released on it
   ufs_reset_sync ctrlReset (
      .mclk(mclk),
      .reset_n(reset_n),
      .assertReq(urReq_q),
      .ctrlReset_n(ctrlReset_n)
   ); // see R10

   // Shared RTS bit: bus write wins a tie with a modem control write,
   // since software issued it last from its point of view
   always_comb begin
      rtsBit_d = rtsBit_q;
      if (localClear) begin
         rtsBit_d = ufs_pkg::SHADOW_RTS_RST;
      end else if (wrDone & selShadowRts) begin
         rtsBit_d = pwdata[ufs_pkg::SHADOW_RTS_BIT]; // see R11
      end else if (modemCtrlWrite) begin
         rtsBit_d = modemCtrlRts; // see R11
      end
   end

   // Flow control: throttle only with auto flow and FIFOs on
   // Equal to threshold still admits
   assign rxAbove = (rxLvl.count > rxThreshold);
   assign throttle = autoFlowEnable & fifoEnable & rxAbove; // see R13
   // Loopback keeps the pin inactive whatever the bit says
   assign rtsDrive = rtsBit_d & ~throttle &
      ~loopbackEnable; // see R12 see R14 see R15

   // Event sources and write-one-to-clear mask
   // Levels do not re-arm cleared bits
   assign evtSet[ufs_pkg::EVT_RX_FULL] = rxLvl.full & ~rxFullPrev_q;
   assign evtSet[ufs_pkg::EVT_TX_EMPTY] = txLvl.empty & ~txEmptyPrev_q;
   assign evtSet[ufs_pkg::EVT_RTS_THROTTLE] = throttle & ~throttlePrev_q;
   assign evtClr = (wrDone & selEvtStatus) ?
      pwdata[ufs_pkg::EVT_W-1:0] : '0;

   // A new event beats a clear arriving in the same cycle
   always_comb begin
      evtStatus_d = (evtStatus_q & ~evtClr) | evtSet;
      evtMask_d = evtMask_q;
      if (wrDone & selEvtMask) begin
         evtMask_d = pwdata[ufs_pkg::EVT_W-1:0];
      end
   end

   // Control and pin registers
   // Pin tracks the next shadow bit
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rtsBit_q <= ufs_pkg::SHADOW_RTS_RST;
         rts_n_q <= 1'b1;
         loopRts_q <= 1'b0;
         fifoEnPrev_q <= 1'b0;
         throttlePrev_q <= 1'b0;
      end else begin
         rtsBit_q <= rtsBit_d;
         rts_n_q <= ~rtsDrive; // see R12
         // Looped value reaches the modem-status input
         loopRts_q <= loopbackEnable & rtsBit_d; // see R14
         fifoEnPrev_q <= fifoEnable;
         throttlePrev_q <= throttle;
      end
   end

   // Strobe pulses: a software strobe lasts one cycle, so the bits self-clear
   // Every flush cause gives a pulse
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         txFlush_q <= 1'b0;
         rxFlush_q <= 1'b0;
         urReq_q <= 1'b0;
      end else begin
         txFlush_q <= txMove.flush; // see R7
         rxFlush_q <= rxMove.flush; // see R8
         urReq_q <= swCtrlReset; // see R10
      end
   end

   // Edge history for the event detectors
   // Reset images match idle FIFOs
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rxFullPrev_q <= 1'b0;
         txEmptyPrev_q <= 1'b1;
      end else begin
         rxFullPrev_q <= rxLvl.full;
         txEmptyPrev_q <= txLvl.empty;
      end
   end

   // Event status, mask and interrupt level from next values
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         evtStatus_q <= ufs_pkg::EVT_RST;
         evtMask_q <= ufs_pkg::EVT_RST;
         irq_q <= 1'b0;
      end else begin
         evtStatus_q <= evtStatus_d;
         evtMask_q <= evtMask_d;
         irq_q <= |(evtStatus_d & evtMask_d);
      end
   end

   // Outputs straight from flip-flops
   // No pin is driven by gates
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign txFifoFlush = txFlush_q;
   assign rxFifoFlush = rxFlush_q;
   assign shadowRts = rtsBit_q;
   assign loopRts = loopRts_q;
   assign rts_n = rts_n_q;
   assign irq = irq_q;

endmodule : ufs_status_shadow
`default_nettype wire

// >>> ufs_status_shadow_chk.sv
// Checker: port-level assertions for the status and shadow block
`timescale 1ns/100ps
`default_nettype none
module ufs_status_shadow_chk (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic fifoEnable,
   input wire logic fifoCtrlTxFlush,
   input wire logic fifoCtrlRxFlush,
   input wire logic autoFlowEnable,
   input wire logic loopbackEnable,
   input wire logic txFifoFlush,
   input wire logic rxFifoFlush,
   input wire logic ctrlReset_n,
   input wire logic shadowRts,
   input wire logic loopRts,
   input wire logic rts_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // Completed bus access to the strobe register
   logic srDone;
   assign srDone = psel && penable && pready &&
      paddr == ufs_pkg::ADDR_SOFT_RESET;
   // Setup then first access cycle, then the single wait state
   sequence accessStart;
      psel && !penable ##1 psel && penable;
   endsequence
   sequence oneWait;
      !pready ##1 pready;
   endsequence
   a_one_wait: assert property (accessStart |-> oneWait)
      else $error("pready not after one wait state");
   a_tx_strobe: assert property (srDone && pwrite && pwdata[2] |=>
      txFifoFlush) else $error("tx flush strobe lost");
   a_rx_strobe: assert property (srDone && pwrite && pwdata[1] |=>
      rxFifoFlush) else $error("rx flush strobe lost");
   a_fcr_tx: assert property (fifoCtrlTxFlush |=> txFifoFlush)
      else $error("tx control flush lost");
   a_fcr_rx: assert property (fifoCtrlRxFlush |=> rxFifoFlush)
      else $error("rx control flush lost");
   a_enable_fall: assert property ($fell(fifoEnable) |=>
      txFifoFlush && rxFifoFlush) else $error("enable fall no flush");
   a_ctrl_reset: assert property (srDone && pwrite && pwdata[0] |->
      ##[1:2] !ctrlReset_n) else $error("controller reset not asserted");
   a_ctrl_release: assert property ($fell(ctrlReset_n) |->
      ##[1:4] ctrlReset_n) else $error("controller reset not released");
   a_rts_follow: assert property (!$past(loopbackEnable) &&
      !$past(autoFlowEnable) |-> rts_n == !shadowRts)
      else $error("rts pin does not follow bit");
   a_rts_loop: assert property ($past(loopbackEnable) |-> rts_n)
      else $error("rts pin low in loopback");
   a_loop_value: assert property (loopRts ==
      ($past(loopbackEnable) && shadowRts)) else $error("loop value wrong");
   a_sr_reads_zero: assert property (srDone && !pwrite |->
      prdata == 32'h00000000) else $error("strobe register read not zero");
endmodule : ufs_status_shadow_chk
bind ufs_status_shadow ufs_status_shadow_chk u_chk (
   .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .fifoEnable(fifoEnable),
   .fifoCtrlTxFlush(fifoCtrlTxFlush), .fifoCtrlRxFlush(fifoCtrlRxFlush),
   .autoFlowEnable(autoFlowEnable), .loopbackEnable(loopbackEnable),
   .txFifoFlush(txFifoFlush), .rxFifoFlush(rxFifoFlush),
   .ctrlReset_n(ctrlReset_n), .shadowRts(shadowRts), .loopRts(loopRts),
   .rts_n(rts_n));
`default_nettype wire
